// ---- inc/lph_params.svh ----
`ifndef LPH_PARAMS_SVH
`define LPH_PARAMS_SVH
`define LPH_IDX_PANEL       6'h30
`define LPH_IDX_MODRATE     6'h31
`define LPH_IDX_HDISP       6'h32
`define LPH_IDX_HBLANK      6'h34
`define LPH_IDX_LPSTART     6'h35
`define LPH_IDX_LPWIDTH     6'h36
`define LPH_IDX_STATUS      6'h3E
`define LPH_IDX_CTRL        6'h3F
`define LPH_PT_EL           7
`define LPH_PT_DW_HI        5
`define LPH_PT_DW_LO        4
`define LPH_PT_FMT          3
`define LPH_PT_COLOR        2
`define LPH_PT_DUAL         1
`define LPH_PT_TFT          0
`define LPH_LW_POL          7
`define LPH_CT_EN           0
`define LPH_CT_BPP16        1
`define LPH_MASK_PANEL      8'hBF
`define LPH_MASK_MODRATE    8'h3F
`define LPH_MASK_HDISP      8'h7F
`define LPH_MASK_HBLANK     8'h1F
`define LPH_MASK_LPSTART    8'h1F
`define LPH_MASK_LPWIDTH    8'h8F
`define LPH_MASK_CTRL       8'h03
`define LPH_REG_RESET       8'h00
`define LPH_LP_OFS_8BPP     11'h004
`define LPH_LP_OFS_16BPP    11'h006
`define LPH_PASSIVE_LP_LEN  11'h008
`define LPH_EL_FRAMES       262143
`define LPH_RESP_OKAY       2'h0
`define LPH_RESP_SLVERR     2'h2
`endif

// ---- inc/lph_pkg.sv ----
`include "lph_params.svh"
package lph_pkg;
    typedef enum logic [1:0] {
        LPH_ACTIVE = 2'b01,
        LPH_BLANK  = 2'b10
    } lph_phase_t;

    typedef logic [5:0] lph_idx_t;

    // Decode shared by the read and the write path
    function automatic logic lph_reg_hit(input lph_idx_t idx);
        logic hit;
        hit = 1'b0;
        case (idx)
            `LPH_IDX_PANEL, `LPH_IDX_MODRATE, `LPH_IDX_HDISP, `LPH_IDX_HBLANK,
            `LPH_IDX_LPSTART, `LPH_IDX_LPWIDTH, `LPH_IDX_STATUS, `LPH_IDX_CTRL:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
        return hit;
    endfunction
endpackage

// ---- verilog/lph_frm_hold.sv ----
`timescale 1ns/10ps
module lph_frm_hold
#(
    parameter int FRAMES = `LPH_EL_FRAMES
)
(
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    // Control and events
    input  wire logic i_enable,
    input  wire logic i_frame_evt,
    // Hold request
    output logic      o_hold
);
    localparam logic [17:0] LAST = 18'(FRAMES - 1);
    logic [17:0] frames;

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            frames <= 18'h0_0000;
            o_hold <= 1'b0;
        end
        else if (i_ce)
        begin
            if (!i_enable)
            begin
                frames <= 18'h0_0000;
                o_hold <= 1'b0;
            end
            else if (i_frame_evt)
            begin
                if (o_hold)
                    o_hold <= 1'b0;
                else if (frames == LAST)
                begin
                    frames <= 18'h0_0000;
                    o_hold <= 1'b1;
                end
                else
                    frames <= frames + 18'h0_0001;
            end
        end
    end
endmodule

// ---- verilog/lph_ac_mod.sv ----
`timescale 1ns/10ps
module lph_ac_mod
(
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic       i_ce,
    // Control and events
    input  wire logic       i_passive,
    input  wire logic [5:0] i_rate,
    input  wire logic       i_line_evt,
    input  wire logic       i_frame_evt,
    // Modulation output
    output logic            o_mod
);
    logic [5:0] lines;

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            lines <= 6'h00;
            o_mod <= 1'b0;
        end
        else if (i_ce)
        begin
            if (!i_passive)
            begin
                lines <= 6'h00;
                o_mod <= 1'b0;
            end
            else if (i_rate == 6'h00)
            begin
                lines <= 6'h00;
                if (i_frame_evt)
                    o_mod <= ~o_mod;
            end
            else if (i_line_evt)
            begin
                // Rate lowered below count still toggles on the next line event
                if (lines + 6'h01 >= i_rate)
                begin
                    lines <= 6'h00;
                    o_mod <= ~o_mod;
                end
                else
                    lines <= lines + 6'h01;
            end
        end
    end
endmodule

// ---- verilog/lph_top.sv ----
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module lph_top
    import lph_pkg::*;
#(
    parameter int FRAMES = `LPH_EL_FRAMES
)
(
    // Clock, reset, enable
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    // Frame event from vertical timing
    input  wire logic        i_frame_start,
    // AXI4-Lite write
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    output logic [1:0]       o_bresp,
    // AXI4-Lite read
    input  wire logic        i_arvalid,
    output logic             o_arready,
    input  wire logic [7:0]  i_araddr,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    // Panel timing
    output logic             o_line_pulse,
    output logic             o_hblank,
    output logic             o_ac_modulation_output,
    output logic             o_grey_dither_hold,
    // Panel configuration
    output logic [4:0]       o_bus_width,
    output logic             o_color_mode,
    output logic             o_dual_panel,
    output logic             o_active_matrix,
    output logic             o_data_format2
);
    logic        rst_meta;
    logic        rst_n;
    logic [7:0]  panel_type_config;
    logic [7:0]  modulation_rate;
    logic [7:0]  horizontal_display_width;
    logic [7:0]  horizontal_blank_period;
    logic [7:0]  line_pulse_start;
    logic [7:0]  line_pulse_width_polarity;
    logic [7:0]  timing_control;
    lph_idx_t    aw_idx;
    logic        aw_got;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        w_got;
    logic        wr_fire;
    logic        wr_hit;
    lph_idx_t    rd_idx;
    logic [7:0]  rd_val;
    lph_phase_t  phase;
    logic [10:0] pix;
    logic [10:0] disp_len;
    logic [10:0] blank_len;
    logic [10:0] lp_start;
    logic [10:0] lp_end;
    logic [10:0] next_pix;
    logic        lp_raw;
    logic        lp_raw_d;
    logic        lp_inv;
    logic        run;
    logic        tft;
    logic        ac_mod;
    logic        dither_hold;

    // Two-flop reset release
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Write capture, either order
    assign wr_fire = aw_got && w_got && !o_bvalid;
    assign wr_hit  = lph_reg_hit(aw_idx);

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_idx    <= 6'h00;
            aw_got    <= 1'b0;
            o_awready <= 1'b0;
        end
        else if (i_ce)
        begin
            if (i_awvalid && o_awready)
            begin
                aw_idx    <= i_awaddr[7:2];
                aw_got    <= 1'b1;
                o_awready <= 1'b0;
            end
            else if (wr_fire)
                aw_got <= 1'b0;
            else if (!aw_got && !o_bvalid)
                o_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_byte   <= 8'h00;
            w_lane0  <= 1'b0;
            w_got    <= 1'b0;
            o_wready <= 1'b0;
        end
        else if (i_ce)
        begin
            if (i_wvalid && o_wready)
            begin
                w_byte   <= i_wdata[7:0];
                w_lane0  <= i_wstrb[0];
                w_got    <= 1'b1;
                o_wready <= 1'b0;
            end
            else if (wr_fire)
                w_got <= 1'b0;
            else if (!w_got && !o_bvalid)
                o_wready <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_bvalid <= 1'b0;
            o_bresp  <= `LPH_RESP_OKAY;
        end
        else if (i_ce)
        begin
            if (wr_fire)
            begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_hit ? `LPH_RESP_OKAY : `LPH_RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // Registers; low byte lane only
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            panel_type_config         <= `LPH_REG_RESET;
            modulation_rate           <= `LPH_REG_RESET;
            horizontal_display_width  <= `LPH_REG_RESET;
            horizontal_blank_period   <= `LPH_REG_RESET;
            line_pulse_start          <= `LPH_REG_RESET;
            line_pulse_width_polarity <= `LPH_REG_RESET;
            timing_control            <= `LPH_REG_RESET;
        end
        else if (i_ce && wr_fire && w_lane0)
        begin
            case (aw_idx)
                `LPH_IDX_PANEL:
                    panel_type_config <= w_byte & `LPH_MASK_PANEL;
                `LPH_IDX_MODRATE:
                    modulation_rate <= w_byte & `LPH_MASK_MODRATE;
                `LPH_IDX_HDISP:
                    horizontal_display_width <= w_byte & `LPH_MASK_HDISP;
                `LPH_IDX_HBLANK:
                    horizontal_blank_period <= w_byte & `LPH_MASK_HBLANK;
                `LPH_IDX_LPSTART:
                    line_pulse_start <= w_byte & `LPH_MASK_LPSTART;
                `LPH_IDX_LPWIDTH:
                    line_pulse_width_polarity <= w_byte & `LPH_MASK_LPWIDTH;
                `LPH_IDX_CTRL:
                    timing_control <= w_byte & `LPH_MASK_CTRL;
                default:
                    timing_control <= timing_control;
            endcase
        end
    end

    // Read path, one word per handshake
    assign rd_idx = i_araddr[7:2];

    always_comb
    begin
        case (rd_idx)
            `LPH_IDX_PANEL:   rd_val = panel_type_config;
            `LPH_IDX_MODRATE: rd_val = modulation_rate;
            `LPH_IDX_HDISP:   rd_val = horizontal_display_width;
            `LPH_IDX_HBLANK:  rd_val = horizontal_blank_period;
            `LPH_IDX_LPSTART: rd_val = line_pulse_start;
            `LPH_IDX_LPWIDTH: rd_val = line_pulse_width_polarity;
            `LPH_IDX_STATUS:  rd_val = {4'h0, lp_raw, dither_hold, ac_mod,
                                        phase == LPH_BLANK};
            `LPH_IDX_CTRL:    rd_val = timing_control;
            default:          rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= `LPH_RESP_OKAY;
        end
        else if (i_ce)
        begin
            if (i_arvalid && o_arready)
            begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rdata   <= {24'h00_0000, rd_val};
                o_rresp   <= lph_reg_hit(rd_idx) ? `LPH_RESP_OKAY : `LPH_RESP_SLVERR;
            end
            else if (o_rvalid && i_rready)
                o_rvalid <= 1'b0;
            else if (!o_rvalid)
                o_arready <= 1'b1;
        end
    end

    // Horizontal lengths in pixels
    assign run       = timing_control[`LPH_CT_EN];
    assign tft       = panel_type_config[`LPH_PT_TFT];
    assign disp_len  = {8'(horizontal_display_width + 8'h01), 3'b000};
    assign blank_len = {2'b00, {1'b0, horizontal_blank_period[4:0]} + 6'h01, 3'b000};
    assign lp_start  = {3'b000, line_pulse_start[4:0], 3'b000}
                     + (timing_control[`LPH_CT_BPP16] ? `LPH_LP_OFS_16BPP
                                                      : `LPH_LP_OFS_8BPP);
    assign lp_end    = lp_start
                     + {3'b000, {1'b0, line_pulse_width_polarity[3:0]} + 5'h01, 3'b000};
    assign next_pix  = pix + 11'h001;

    // Line phase machine; pix restarts each phase
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= LPH_ACTIVE;
            pix   <= 11'h000;
        end
        else if (i_ce)
        begin
            if (!run)
            begin
                phase <= LPH_ACTIVE;
                pix   <= 11'h000;
            end
            else
            begin
                case (phase)
                    LPH_ACTIVE:
                    begin
                        if (next_pix >= disp_len)
                        begin
                            phase <= LPH_BLANK;
                            pix   <= 11'h000;
                        end
                        else
                            pix <= next_pix;
                    end
                    LPH_BLANK:
                    begin
                        if (next_pix >= blank_len)
                        begin
                            phase <= LPH_ACTIVE;
                            pix   <= 11'h000;
                        end
                        else
                            pix <= next_pix;
                    end
                    default:
                    begin
                        phase <= LPH_ACTIVE;
                        pix   <= 11'h000;
                    end
                endcase
            end
        end
    end

    // Overlong active-panel pulse is clipped at blank end
    always_comb
    begin
        if (!run || phase != LPH_BLANK)
            lp_raw = 1'b0;
        else if (tft)
            lp_raw = (pix >= lp_start) && (pix < lp_end);
        else
            lp_raw = pix < `LPH_PASSIVE_LP_LEN;
    end

    assign lp_inv = line_pulse_width_polarity[`LPH_LW_POL] ^ tft;

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lp_raw_d     <= 1'b0;
            o_line_pulse <= 1'b0;
            o_hblank     <= 1'b0;
        end
        else if (i_ce)
        begin
            lp_raw_d     <= lp_raw;
            o_line_pulse <= lp_raw ^ lp_inv;
            o_hblank     <= run && (phase == LPH_BLANK);
        end
    end

    // Modulation toggle, counted on line pulse leading edges
    lph_ac_mod u_ac_mod
    (
        .i_mclk      (i_mclk),
        .i_rstn      (rst_n),
        .i_ce        (i_ce),
        .i_passive   (!tft),
        .i_rate      (modulation_rate[5:0]),
        .i_line_evt  (lp_raw && !lp_raw_d),
        .i_frame_evt (i_frame_start),
        .o_mod       (ac_mod)
    );

    assign o_ac_modulation_output = ac_mod;

    // Dither hold for electroluminescent panels
    lph_frm_hold
    #(
        .FRAMES (FRAMES)
    )
    u_frm_hold
    (
        .i_mclk      (i_mclk),
        .i_rstn      (rst_n),
        .i_ce        (i_ce),
        .i_enable    (panel_type_config[`LPH_PT_EL]),
        .i_frame_evt (i_frame_start),
        .o_hold      (dither_hold)
    );

    assign o_grey_dither_hold = dither_hold;

    // Config decode; reserved width code gives zero
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_bus_width     <= 5'h00;
            o_color_mode    <= 1'b0;
            o_dual_panel    <= 1'b0;
            o_active_matrix <= 1'b0;
            o_data_format2  <= 1'b0;
        end
        else if (i_ce)
        begin
            case (panel_type_config[`LPH_PT_DW_HI:`LPH_PT_DW_LO])
                2'b00:   o_bus_width <= tft ? 5'd9  : 5'd4;
                2'b01:   o_bus_width <= tft ? 5'd12 : 5'd8;
                2'b10:   o_bus_width <= tft ? 5'd18 : 5'd16;
                default: o_bus_width <= 5'h00;
            endcase
            o_color_mode    <= panel_type_config[`LPH_PT_COLOR];
            o_dual_panel    <= panel_type_config[`LPH_PT_DUAL];
            o_active_matrix <= tft;
            o_data_format2  <= panel_type_config[`LPH_PT_FMT];
        end
    end
endmodule

// ---- tb/lph_panel_model.sv ----
`timescale 1ns/10ps
module lph_panel_model
(
    // Clock
    input  wire logic   i_mclk,
    // Panel timing pins
    input  wire logic   i_line_pulse,
    input  wire logic   i_hblank,
    // Measured line shape
    output logic [10:0] o_act_len,
    output logic [10:0] o_blk_len,
    output logic [10:0] o_pstart,
    output logic [10:0] o_pend,
    output logic        o_idle
);
    logic [10:0] cnt = 11'h000;
    logic        hb_d = 1'b0;
    logic        lp_d = 1'b0;
    logic        seen = 1'b0;
    logic [10:0] idx;
    assign idx = hb_d ? cnt : 11'h000;
    // Panel only listens; it cannot stall the line timing
    always @(posedge i_mclk)
    begin
        hb_d <= i_hblank;
        lp_d <= i_line_pulse;
        cnt <= (i_hblank != hb_d) ? 11'h001 : cnt + 11'h001;
        if (i_hblank && !hb_d)
        begin
            o_act_len <= cnt;
            o_idle <= lp_d;
            seen <= 1'b0;
        end
        if (!i_hblank && hb_d)
            o_blk_len <= cnt;
        if (i_hblank && i_line_pulse != lp_d)
        begin
            if (!hb_d || !seen)
                o_pstart <= idx;
            else
                o_pend <= idx;
            seen <= 1'b1;
        end
    end
endmodule

// ---- tb/lph_top_chk_sva.sv ----
`timescale 1ns/10ps
module lph_top_chk
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    // Inputs watched
    input  wire logic        i_frame_start,
    input  wire logic        i_arvalid,
    input  wire logic        i_bready,
    input  wire logic        i_rready,
    // Outputs watched
    input  wire logic        o_awready,
    input  wire logic        o_wready,
    input  wire logic        o_bvalid,
    input  wire logic [1:0]  o_bresp,
    input  wire logic        o_arready,
    input  wire logic        o_rvalid,
    input  wire logic [31:0] o_rdata,
    input  wire logic        o_hblank,
    input  wire logic        o_line_pulse,
    input  wire logic        o_ac_modulation_output,
    input  wire logic        o_grey_dither_hold,
    input  wire logic [4:0]  o_bus_width,
    input  wire logic        o_active_matrix
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("bresp dropped");
    chk_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("rdata dropped");
    chk_rdata_upper: assert property (o_rvalid |-> o_rdata[31:8] == 24'h00_0000)
        else $error("rdata upper set");
    chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("Read answer late");
    chk_write_busy: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("Write ready in resp");
    chk_width_active: assert property (o_active_matrix |->
        o_bus_width inside {5'h00, 5'h09, 5'h0C, 5'h12}) else $error("Bad active width");
    chk_width_passive: assert property (!o_active_matrix |->
        o_bus_width inside {5'h00, 5'h04, 5'h08, 5'h10}) else $error("Bad passive width");
    chk_blank_min: assert property ($rose(o_hblank) |-> o_hblank [*8])
        else $error("Blank shorter than 8");
    chk_active_min: assert property ($fell(o_hblank) |-> !o_hblank [*8])
        else $error("Active shorter than 8");
    chk_passive_pulse: assert property (!o_active_matrix && $rose(o_hblank) |->
        $changed(o_line_pulse) ##8 $changed(o_line_pulse)) else $error("Passive pulse shape");
    chk_mod_passive: assert property (o_active_matrix ##1 o_active_matrix |->
        !o_ac_modulation_output) else $error("Modulation on active panel");
    chk_hold_cause: assert property ($rose(o_grey_dither_hold) |->
        $past(i_frame_start) || $past(i_frame_start, 2)) else $error("Hold without frame");
endmodule

bind lph_top lph_top_chk i_chk (.*);

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`include "lph_params.svh"
module testbench;
    localparam int FR = 4;
    localparam logic [7:0] ADR [7] = '{8'hC0, 8'hC4, 8'hC8, 8'hD0, 8'hD4, 8'hD8, 8'hFC};
    localparam logic [7:0] MSK [7] = '{`LPH_MASK_PANEL, `LPH_MASK_MODRATE, `LPH_MASK_HDISP,
        `LPH_MASK_HBLANK, `LPH_MASK_LPSTART, `LPH_MASK_LPWIDTH, `LPH_MASK_CTRL};
    logic        i_mclk = 1'b0, i_rstn = 1'b0, i_frame_start = 1'b0;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0]  i_wstrb = 4'h0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp, rr;
    logic [31:0] o_rdata, rd;
    logic        o_line_pulse, o_hblank, o_ac_modulation_output, o_grey_dither_hold;
    logic [4:0]  o_bus_width;
    logic        o_color_mode, o_dual_panel, o_active_matrix, o_data_format2;
    logic [10:0] m_act, m_blk, m_st, m_en;
    logic        m_idle, tft, pol, b16, m0;
    logic [7:0]  d, p, hd, hn, st, lw, rt;
    logic [7:0]  sh [7];
    int          num_errors = 0, checked = 0, cyc = 0, i, j, n;

    lph_top #(.FRAMES(FR)) i_dut (.i_ce(1'b1), .*);
    lph_panel_model i_panel (.i_mclk, .i_line_pulse(o_line_pulse), .i_hblank(o_hblank),
        .o_act_len(m_act), .o_blk_len(m_blk), .o_pstart(m_st), .o_pend(m_en), .o_idle(m_idle));

    always #5 i_mclk = ~i_mclk;

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bready may lag on purpose so a held response is seen
    task automatic axw(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s,
                       input int dl, output logic [1:0] r);
        logic got = 1'b0;
        int k = 0;
        @(posedge i_mclk);
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wvalid <= 1'b1;
        i_wdata <= {24'h00_0000, v};
        i_wstrb <= s;
        i_bready <= (dl == 0);
        while (!got)
        begin
            @(posedge i_mclk);
            k++;
            if (i_awvalid && o_awready)
                i_awvalid <= 1'b0;
            if (i_wvalid && o_wready)
                i_wvalid <= 1'b0;
            if (i_bready && o_bvalid)
            begin
                r = o_bresp;
                got = 1'b1;
                i_bready <= 1'b0;
            end
            else if (k >= dl)
                i_bready <= 1'b1;
        end
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r,
                       input int dl);
        logic got = 1'b0;
        int k = 0;
        @(posedge i_mclk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= (dl == 0);
        while (!got)
        begin
            @(posedge i_mclk);
            k++;
            if (i_arvalid && o_arready)
                i_arvalid <= 1'b0;
            if (i_rready && o_rvalid)
            begin
                v = o_rdata;
                r = o_rresp;
                got = 1'b1;
                i_rready <= 1'b0;
            end
            else if (k >= dl)
                i_rready <= 1'b1;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [1:0] r;
        axw(a, v, 4'hF, 0, r);
        check(r, `LPH_RESP_OKAY);
    endtask

    task automatic rises(input int c);
        logic hbp = o_hblank;
        while (c > 0)
        begin
            @(negedge i_mclk);
            if (o_hblank && !hbp)
                c--;
            hbp = o_hblank;
        end
    endtask

    // Reprogram only in the active phase so no blank is cut short
    task automatic cfg(input logic [7:0] cp, ch, cn, cs, cw, ct);
        for (int k = 0; k < 1100 && !o_hblank; k++)
            @(negedge i_mclk);
        while (o_hblank)
            @(negedge i_mclk);
        wr(8'hFC, 8'h00);
        wr(8'hC0, cp);
        wr(8'hC8, ch);
        wr(8'hD0, cn);
        wr(8'hD4, cs);
        wr(8'hD8, cw);
        wr(8'hFC, ct);
    endtask

    task automatic frame();
        @(posedge i_mclk);
        i_frame_start <= 1'b1;
        @(posedge i_mclk);
        i_frame_start <= 1'b0;
        repeat (3) @(negedge i_mclk);
    endtask

    task automatic meas(output int c);
        logic m = o_ac_modulation_output, hbp;
        c = 0;
        while (o_ac_modulation_output === m)
            @(negedge i_mclk);
        m = o_ac_modulation_output;
        hbp = o_hblank;
        while (o_ac_modulation_output === m)
        begin
            @(negedge i_mclk);
            if (o_hblank && !hbp)
                c++;
            hbp = o_hblank;
        end
    endtask

    function automatic logic [4:0] exp_bw(input logic [7:0] v);
        case (v[5:4])
            2'b00: return v[0] ? 5'h09 : 5'h04;
            2'b01: return v[0] ? 5'h0C : 5'h08;
            2'b10: return v[0] ? 5'h12 : 5'h10;
            default: return 5'h00;
        endcase
    endfunction

    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            num_errors++;
            close_out();
        end
    end

    initial
    begin
        void'($urandom(24833));
        repeat (10) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_mclk);
        for (j = 0; j < 8; j++)
        begin
            axr(j < 7 ? ADR[j] : 8'hF8, rd, rr, 0);
            check(rd, 32'h0000_0000);
            check(rr, `LPH_RESP_OKAY);
        end
        axr(8'hE0, rd, rr, 1);
        check(rd, 32'h0000_0000);
        check(rr, `LPH_RESP_SLVERR);
        axw(8'hE0, 8'hFF, 4'hF, 0, rr);
        check(rr, `LPH_RESP_SLVERR);
        for (j = 0; j < 14; j++)
        begin
            d = 8'($urandom) & (j % 7 == 6 ? 8'hFE : 8'hFF);
            sh[j % 7] = d & MSK[j % 7];
            axw(ADR[j % 7], d, 4'hF, $urandom % 3, rr);
            check(rr, `LPH_RESP_OKAY);
            axr(ADR[j % 7], rd, rr, $urandom % 3);
            check(rd, sh[j % 7]);
            check(rr, `LPH_RESP_OKAY);
        end
        axw(8'hC4, 8'h15, 4'h0, 0, rr);
        axr(8'hC4, rd, rr, 0);
        check(rd, sh[1]);
        for (i = 0; i < 8; i++)
        begin
            tft = i[0];
            pol = i[1];
            b16 = i[2];
            p = (8'($urandom) & 8'h3E) | {7'h00, tft};
            hd = 8'd3 + 8'd4 * 8'($urandom % 3);
            st = 8'($urandom % 4);
            lw = 8'($urandom % 4);
            hn = st + lw + 8'd1 + 8'($urandom % 4);
            cfg(p, hd, hn, st, {pol, 3'h0, lw[3:0]}, {6'h00, b16, 1'b1});
            repeat (2) @(negedge i_mclk);
            check(o_bus_width, exp_bw(p));
            check(o_data_format2, p[3]);
            check(o_color_mode, p[2]);
            check(o_dual_panel, p[1]);
            check(o_active_matrix, p[0]);
            rises(3);
            repeat (3) @(negedge i_mclk);
            check(m_act, (hd + 1) * 8);
            check(m_blk, (hn + 1) * 8);
            check(m_st, tft ? st * 8 + (b16 ? 6 : 4) : 0);
            check(m_en - m_st, tft ? (lw + 1) * 8 : 8);
            check(m_idle, pol ^ tft);
        end
        cfg(8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01);
        for (i = 0; i < 3; i++)
        begin
            rt = (i == 0) ? 8'h01 : (i == 1) ? 8'h3F : 8'(2 + $urandom % 8);
            wr(8'hC4, rt);
            meas(n);
            check(n, rt);
        end
        wr(8'hC4, 8'h00);
        rises(1);
        m0 = o_ac_modulation_output;
        rises(3);
        check(o_ac_modulation_output, m0);
        frame();
        check(o_ac_modulation_output, !m0);
        wr(8'hC0, 8'h80);
        for (i = 1; i < 6; i++)
        begin
            frame();
            check(o_grey_dither_hold, i == FR);
        end
        close_out();
    end
endmodule
